//--- design/bsr_pkg.sv
// Package: constants and carrier types for the banked core register block
package bsr_pkg;

	// Register map offsets, banks 2 and 3
	localparam logic [8:0] ADDR_INDIRECT_B2 = 9'h100;
	localparam logic [8:0] ADDR_TIMER_B2    = 9'h101;
	localparam logic [8:0] ADDR_PCL_B2      = 9'h102;
	localparam logic [8:0] ADDR_STATUS_B2   = 9'h103;
	localparam logic [8:0] ADDR_FSR_B2      = 9'h104;
	localparam logic [8:0] ADDR_PORT_B_LATCH_B2    = 9'h106;
	localparam logic [8:0] ADDR_PC_UPPER_HOLDING_B2   = 9'h10a;
	localparam logic [8:0] ADDR_INTERRUPT_CONTROL_B2   = 9'h10b;
	localparam logic [8:0] ADDR_INDIRECT_B3 = 9'h180;
	localparam logic [8:0] ADDR_OPTION      = 9'h181;
	localparam logic [8:0] ADDR_PCL_B3      = 9'h182;
	localparam logic [8:0] ADDR_STATUS_B3   = 9'h183;
	localparam logic [8:0] ADDR_FSR_B3      = 9'h184;
	localparam logic [8:0] ADDR_PORT_B_DIRECTION       = 9'h186;
	localparam logic [8:0] ADDR_PC_UPPER_HOLDING_B3   = 9'h18a;
	localparam logic [8:0] ADDR_INTERRUPT_CONTROL_B3   = 9'h18b;

	// First general purpose location of a bank; below it only listed registers exist
	localparam logic [6:0] LOW_FIRST_GPR = 7'h10;

	// Locations absent on the smaller package (port D and E data and direction)
	localparam logic [8:0] ADDR_ABSENT_0 = 9'h008;
	localparam logic [8:0] ADDR_ABSENT_1 = 9'h009;
	localparam logic [8:0] ADDR_ABSENT_2 = 9'h088;
	localparam logic [8:0] ADDR_ABSENT_3 = 9'h089;

	// Status bit positions
	localparam int ST_IRP = 7;
	localparam int ST_RP1 = 6;
	localparam int ST_RP0 = 5;
	localparam int ST_TO  = 4;
	localparam int ST_PD  = 3;
	localparam int ST_Z   = 2;
	localparam int ST_DC  = 1;
	localparam int ST_C   = 0;

	// Widths
	localparam int PC_UPPER_HOLDING_W = 5;
	localparam int PC_W     = 13;
	localparam int JUMP_W   = 11;

	// Values after reset
	localparam logic [7:0]          STATUS_POR  = 8'h18;
	localparam logic [7:0]          OPTION_RST  = 8'hff;
	localparam logic [7:0]          PORT_B_DIRECTION_RST   = 8'hff;
	localparam logic [7:0]          INTERRUPT_CONTROL_RST  = 8'h00;
	localparam logic [7:0]          FSR_RST     = 8'h00;
	localparam logic [PC_UPPER_HOLDING_W-1:0] PC_UPPER_HOLDING_RST  = 5'h00;
	localparam logic [PC_W-1:0]     PC_RST      = 13'h0000;

	// Operation applied to operands before the write
	typedef enum logic [1:0] {
		ALU_PASS = 2'b00,
		ALU_ADD  = 2'b01,
		ALU_SUB  = 2'b11
	} bsr_alu_op_e;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} bsr_flags_s;

	// One instruction's register access from the core
	typedef struct packed {
		logic        valid;
		logic        rd;
		logic        wr;
		logic [6:0]  file_addr;
		bsr_alu_op_e op;
		logic [7:0]  a;
		logic [7:0]  b;
		bsr_flags_s  flag_en;
	} bsr_req_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} bsr_rsp_s;

	// Access passed on to memory outside this block
	typedef struct packed {
		logic       valid;
		logic       wr;
		logic [8:0] addr;
		logic [7:0] wdata;
	} bsr_ext_s;

	// Reset and power events from the reset and sleep logic
	typedef struct packed {
		logic master_clear;
		logic watchdog;
		logic sleep;
		logic wdt_clear;
	} bsr_event_s;

endpackage : bsr_pkg

//--- design/bsr_flag_alu.sv
// Module: add, subtract or pass operands and derive zero, nibble carry and carry
`timescale 1ns/100ps
module bsr_flag_alu
	import bsr_pkg::*;
(
	input  wire bsr_alu_op_e op_in,
	input  wire logic [7:0]  a_in,
	input  wire logic [7:0]  b_in,
	output logic [7:0]       result_out,
	output bsr_flags_s       flags_out
);

	logic       is_sub;
	logic [7:0] b_eff;
	logic       cin;
	logic [8:0] sum;
	logic [4:0] nib;

	// Subtract as a plus the two's complement of b, so carry is an inverted borrow
	assign is_sub = (op_in == ALU_SUB);
	assign b_eff  = is_sub ? ~b_in : b_in;
	assign cin    = is_sub;
	assign sum    = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, cin};
	assign nib    = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};

	// Pass hands b straight through; its carries are meaningless and forced to zero here
	assign result_out   = (op_in == ALU_PASS) ? b_in : sum[7:0];
	assign flags_out.z  = (result_out == 8'h00);
	assign flags_out.dc = (op_in != ALU_PASS) && nib[4];
	assign flags_out.c  = (op_in != ALU_PASS) && sum[8];

endmodule : bsr_flag_alu

//--- design/bsr_banked_sfr.sv
// Module: banked core registers, status logic and program counter upper holding
`timescale 1ns/100ps
module bsr_banked_sfr
	import bsr_pkg::*;
(
	// Clock and power-up reset
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	// Core access, reset-cause events and package strap
	input  wire bsr_pkg::bsr_req_s   req_in,
	input  wire bsr_pkg::bsr_event_s event_in,
	input  wire logic                small_package_in,
	// Program counter sequencing from the core
	input  wire logic                pc_inc_in,
	input  wire logic                pc_jump_in,
	input  wire logic [10:0]         pc_target_in,
	// Registered answers and register contents
	output bsr_pkg::bsr_rsp_s        rsp_out,
	output bsr_pkg::bsr_ext_s        ext_out,
	output logic [12:0]              pc_out,
	output logic [7:0]               status_out,
	output logic [7:0]               option_out,
	output logic [7:0]               port_b_direction_out,
	output logic [7:0]               interrupt_control_out
);

	// Register state
	logic [7:0]          status_q;
	logic [7:0]          status_d;
	logic [7:0]          fsr_q;
	logic [7:0]          interrupt_control_q;
	logic [7:0]          option_q;
	logic [7:0]          port_b_direction_q;
	logic [PC_UPPER_HOLDING_W-1:0] pc_upper_holding_q;
	logic [PC_W-1:0]     pc_q;
	logic [PC_W-1:0]     pc_d;
	logic                pkg_meta_q;
	logic                pkg_small_q;
	bsr_rsp_s            rsp_q;
	bsr_ext_s            ext_q;

	// Decode wires
	logic                soft_rst;
	logic                ind_sel;
	logic [8:0]          eff_addr;
	logic [6:0]          low7;
	logic                null_ind;
	logic                hit_pcl;
	logic                hit_status;
	logic                hit_fsr;
	logic                hit_pc_upper_holding;
	logic                hit_interrupt_control;
	logic                hit_option;
	logic                hit_port_b_direction;
	logic                local_hit;
	logic                unimpl;
	logic                absent;
	logic                ext_sel;
	logic                do_wr;
	logic [7:0]          rd_mux;
	logic [7:0]          wval;
	bsr_flags_s          alu_flags;
	bsr_flags_s          flag_upd;
	logic                flag_any;
	logic                hit_timer;
	logic                hit_port_b_latch;
	logic [3:0]          absent_hit;
	// Write qualifiers for status and the program counter path
	logic                st_bank_wr;
	logic                st_arith_wr;
	logic                pc_low_wr;
	logic                hold_wr;

	// Operand path shared by every write and by the flag update
	bsr_flag_alu u_alu (
		.op_in      (req_in.op),
		.a_in       (req_in.a),
		.b_in       (req_in.b),
		.result_out (wval),
		.flags_out  (alu_flags)
	);

	// Package strap comes from a pin, so it is synchronised before use
	// Until the second flop settles the full register map applies
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pkg_meta_q  <= 1'b0;
			pkg_small_q <= 1'b0;
		end else begin
			pkg_meta_q  <= small_package_in;
			pkg_small_q <= pkg_meta_q;
		end
	end

	// Master clear and watchdog resets share the non-power-up values
	assign soft_rst = event_in.master_clear | event_in.watchdog;

	// Address formation: location 0 redirects through the pointer and indirect bank bit
	// Pointer addressing reaches all four banks through the indirect bank bit and pointer bit 7
	assign ind_sel  = (req_in.file_addr == ADDR_INDIRECT_B2[6:0]);
	assign eff_addr = ind_sel ? {status_q[ST_IRP], fsr_q}
	                          : {status_q[ST_RP1], status_q[ST_RP0], req_in.file_addr};
	assign low7     = eff_addr[6:0];
	// Indirect through the port itself has no register behind it
	assign null_ind = (low7 == ADDR_INDIRECT_B2[6:0]);

	// Globals ignore both bank bits, so every bank reaches the same flip-flops
	assign hit_pcl    = (low7 == ADDR_PCL_B2[6:0]);
	assign hit_status = (low7 == ADDR_STATUS_B2[6:0]);
	assign hit_fsr    = (low7 == ADDR_FSR_B2[6:0]);
	assign hit_pc_upper_holding = (low7 == ADDR_PC_UPPER_HOLDING_B2[6:0]);
	assign hit_interrupt_control = (low7 == ADDR_INTERRUPT_CONTROL_B2[6:0]);
	// Option and direction are shared by banks 1 and 3 only
	assign hit_option = eff_addr[7] && (low7 == ADDR_OPTION[6:0]);
	assign hit_port_b_direction  = eff_addr[7] && (low7 == ADDR_PORT_B_DIRECTION[6:0]);
	assign local_hit  = hit_pcl | hit_status | hit_fsr | hit_pc_upper_holding | hit_interrupt_control
	                  | hit_option | hit_port_b_direction;

	// Timer count and port latch live outside this block, and in banks 0 and 2 only
	assign hit_timer = !eff_addr[7] && (low7 == ADDR_TIMER_B2[6:0]);
	assign hit_port_b_latch = !eff_addr[7] && (low7 == ADDR_PORT_B_LATCH_B2[6:0]);

	// Banks 2 and 3 below the first RAM byte hold nothing else but, in bank 2, timer and port latch
	assign unimpl = eff_addr[8] && (low7 < LOW_FIRST_GPR) && !local_hit && !null_ind
	              && !hit_timer && !hit_port_b_latch;

	// Port D and E registers do not exist on the smaller package
	localparam logic [8:0] ABSENT_ADDR [4] = '{ADDR_ABSENT_0, ADDR_ABSENT_1,
	                                           ADDR_ABSENT_2, ADDR_ABSENT_3};

	// One comparator per missing location; the strap gates them all at once
	for (genvar g = 0; g < 4; g++) begin : g_absent
		assign absent_hit[g] = (eff_addr == ABSENT_ADDR[g]);
	end
	assign absent = pkg_small_q && (absent_hit != 4'h0);

	assign ext_sel = !local_hit && !unimpl && !absent && !null_ind;
	assign do_wr   = req_in.valid && req_in.wr && !soft_rst;

	// Writes that feed the program counter path
	assign pc_low_wr = do_wr && hit_pcl;
	assign hold_wr   = do_wr && hit_pc_upper_holding;

	// Read selection; anything not matched reads zero
	assign rd_mux = hit_pcl    ? pc_q[7:0] :
	                hit_status ? status_q :
	                hit_fsr    ? fsr_q :
	                hit_pc_upper_holding ? {3'h0, pc_upper_holding_q} :
	                hit_interrupt_control ? interrupt_control_q :
	                hit_option ? option_q :
	                hit_port_b_direction  ? port_b_direction_q : 8'h00;

	// Flags to load from the operation; an idle bus or a reset cycle leaves them alone
	assign flag_upd.z  = req_in.valid && req_in.flag_en.z && !soft_rst;
	assign flag_upd.dc = req_in.valid && req_in.flag_en.dc && !soft_rst;
	assign flag_upd.c  = req_in.valid && req_in.flag_en.c && !soft_rst;
	assign flag_any    = flag_upd.z | flag_upd.dc | flag_upd.c;

	// A flag-setting instruction owns all three flags, so its data byte never reaches them
	assign st_bank_wr  = do_wr && hit_status;
	assign st_arith_wr = st_bank_wr && !flag_any;

	// Status next value: data write, then flag override, then power events
	always_comb begin
		status_d = status_q;
		// Bank bits take the data byte like any other file register
		if (st_bank_wr) begin
			status_d[ST_IRP] = wval[ST_IRP];
			status_d[ST_RP1] = wval[ST_RP1];
			status_d[ST_RP0] = wval[ST_RP0];
		end
		// Timeout and power-down have no data path; flags only without a flag update
		if (st_arith_wr) begin
			status_d[ST_Z]  = wval[ST_Z];
			status_d[ST_DC] = wval[ST_DC];
			status_d[ST_C]  = wval[ST_C];
		end
		// Result flags replace the data byte, so clearing status sets Z and keeps DC and C
		if (flag_upd.z) begin
			status_d[ST_Z] = alu_flags.z;
		end
		if (flag_upd.dc) begin
			status_d[ST_DC] = alu_flags.dc;
		end
		if (flag_upd.c) begin
			status_d[ST_C] = alu_flags.c;
		end
		// Sleep and watchdog clear logic move the power flags; a watchdog reset also drops timeout below
		if (event_in.sleep) begin
			status_d[ST_TO] = 1'b1;
			status_d[ST_PD] = 1'b0;
		end else if (event_in.wdt_clear) begin
			status_d[ST_TO] = 1'b1;
			status_d[ST_PD] = 1'b1;
		end
		// Non-power-up reset clears banks and keeps arithmetic flags
		if (soft_rst) begin
			status_d[ST_IRP] = 1'b0;
			status_d[ST_RP1] = 1'b0;
			status_d[ST_RP0] = 1'b0;
			// Only a watchdog reset drops timeout; master clear leaves both power flags
			if (event_in.watchdog) begin
				status_d[ST_TO] = 1'b0;
			end
		end
	end

	// Status register; arithmetic flags get a defined zero rather than unknown
	// Software must not rely on that zero, since the flags are undefined at power-up
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			status_q <= STATUS_POR;
		end else begin
			status_q <= status_d;
		end
	end

	// Program counter: a low byte write pulls the upper bits from the holding register
	always_comb begin
		pc_d = pc_q;
		if (soft_rst) begin
			// A reset cause restarts at the vector and beats any instruction
			pc_d = PC_RST;
		end else if (pc_low_wr) begin
			// All five holding bits go above the written low byte
			pc_d = {pc_upper_holding_q, wval};
		end else if (pc_jump_in) begin
			// Only two holding bits sit above the eleven-bit jump target
			pc_d = {pc_upper_holding_q[4:3], pc_target_in};
		end else if (pc_inc_in) begin
			pc_d = pc_q + 13'h0001;
		end
	end

	// Program counter flop; only power-up reset acts here, other causes come through pc_d
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pc_q <= PC_RST;
		end else begin
			pc_q <= pc_d;
		end
	end

	// Holding register keeps only five bits; the rest read as zero
	always_ff @(posedge clk_in) begin
		if (rst_in || soft_rst) begin
			pc_upper_holding_q <= PC_UPPER_HOLDING_RST;
		end else if (hold_wr) begin
			pc_upper_holding_q <= wval[PC_UPPER_HOLDING_W-1:0];
		end
	end

	// Pointer survives every reset but power-up
	// Zero at power-up keeps the first indirect access from reading unknown data
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fsr_q <= FSR_RST;
		end else if (do_wr && hit_fsr) begin
			fsr_q <= wval;
		end
	end

	// Interrupt control; the port-change flag is kept over non-power-up resets
	// That flag is set by port logic elsewhere, so a reset cause must not erase it
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			interrupt_control_q <= INTERRUPT_CONTROL_RST;
		end else if (soft_rst) begin
			interrupt_control_q <= {INTERRUPT_CONTROL_RST[7:1], interrupt_control_q[0]};
		end else if (do_wr && hit_interrupt_control) begin
			interrupt_control_q <= wval;
		end
	end

	// Timer options return to all ones on any reset
	always_ff @(posedge clk_in) begin
		if (rst_in || soft_rst) begin
			option_q <= OPTION_RST;
		end else if (do_wr && hit_option) begin
			option_q <= wval;
		end
	end

	// Port B direction also returns to all ones, leaving every pin an input
	always_ff @(posedge clk_in) begin
		if (rst_in || soft_rst) begin
			port_b_direction_q <= PORT_B_DIRECTION_RST;
		end else if (do_wr && hit_port_b_direction) begin
			port_b_direction_q <= wval;
		end
	end

	// Read answer one cycle after the request, zero for foreign locations
	// Data moves every cycle; only the valid bit says that it answers a read
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= req_in.valid && req_in.rd && !soft_rst;
			rsp_q.rdata <= rd_mux;
		end
	end

	// Foreign accesses go out registered, with the bank-resolved address
	// Address and data follow the bus every cycle; the receiver must qualify with valid
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ext_q <= '0;
		end else begin
			ext_q.valid <= req_in.valid && (req_in.rd || req_in.wr) && ext_sel && !soft_rst;
			ext_q.wr    <= req_in.wr;
			ext_q.addr  <= eff_addr;
			ext_q.wdata <= wval;
		end
	end

	// Every output is a flop, so no decode path reaches a pin
	assign rsp_out    = rsp_q;
	assign ext_out    = ext_q;
	assign pc_out     = pc_q;
	assign status_out = status_q;
	assign option_out = option_q;
	assign port_b_direction_out  = port_b_direction_q;
	assign interrupt_control_out = interrupt_control_q;

endmodule : bsr_banked_sfr

//--- verif/bsr_banked_sfr_checker.sv
// Checker: port-level properties of the banked core register block
`timescale 1ns/100ps
module bsr_banked_sfr_checker
	import bsr_pkg::*;
(
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	input  wire bsr_pkg::bsr_req_s   req_in,
	input  wire bsr_pkg::bsr_event_s event_in,
	input  wire logic                small_package_in,
	input  wire logic                pc_inc_in,
	input  wire logic                pc_jump_in,
	input  wire logic [10:0]         pc_target_in,
	input  wire bsr_pkg::bsr_rsp_s   rsp_out,
	input  wire bsr_pkg::bsr_ext_s   ext_out,
	input  wire logic [12:0]         pc_out,
	input  wire logic [7:0]          status_out,
	input  wire logic [7:0]          option_out,
	input  wire logic [7:0]          port_b_direction_out,
	input  wire logic [7:0]          interrupt_control_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Requests are dropped in a non-power-up reset cycle, so they must not be judged
	wire       quiet   = !event_in.master_clear && !event_in.watchdog;
	wire       took_rd = req_in.valid && req_in.rd && quiet;
	wire [7:0] res     = (req_in.op == ALU_SUB) ? req_in.a - req_in.b :
		(req_in.op == ALU_ADD) ? req_in.a + req_in.b : req_in.b;
	wire       zr      = res == 8'h00;
	wire       c_ok    = req_in.a >= req_in.b;
	wire       dc_ok   = req_in.a[3:0] >= req_in.b[3:0];
	sequence s_take(fa);
		req_in.valid && quiet && req_in.file_addr == fa;
	endsequence
	property p_por;
		$fell(rst_in) |-> status_out == STATUS_POR && pc_out == PC_RST;
	endproperty
	property p_status_read;
		s_take(7'h03) ##0 (req_in.rd && !req_in.wr) |=>
			rsp_out.valid && rsp_out.rdata == $past(status_out);
	endproperty
	property p_unimpl;
		s_take(7'h05) ##0 (req_in.rd && status_out[ST_RP1]) |=>
			rsp_out.valid && rsp_out.rdata == 8'h00;
	endproperty
	property p_tp_hold;
		quiet && !event_in.sleep && !event_in.wdt_clear |=> $stable(status_out[4:3]);
	endproperty
	property p_wdt;
		event_in.watchdog |=>
			status_out[7:4] == 4'h0 && status_out[3:0] == $past(status_out[3:0]);
	endproperty
	property p_master_clear_pin;
		event_in == 4'b1000 |=> status_out == {3'b000, $past(status_out[4:0])};
	endproperty
	property p_sub;
		req_in.valid && quiet && req_in.op == ALU_SUB && req_in.flag_en == 3'b111 |=>
			status_out[1:0] == {$past(dc_ok), $past(c_ok)};
	endproperty
	property p_zero;
		req_in.valid && quiet && req_in.flag_en.z |=> status_out[ST_Z] == $past(zr);
	endproperty
	property p_pcl;
		s_take(7'h02) ##0 (req_in.wr && req_in.op == ALU_PASS && !pc_inc_in && !pc_jump_in)
			|=> pc_out[7:0] == $past(req_in.b);
	endproperty
	property p_rsp;
		rsp_out.valid |-> $past(took_rd);
	endproperty
	a_por: assert property (p_por) else $error("status or pc wrong after reset");
	a_status_read: assert property (p_status_read) else $error("status read wrong");
	a_unimpl: assert property (p_unimpl) else $error("unimplemented not zero");
	a_tp_hold: assert property (p_tp_hold) else $error("timeout/power flag moved");
	a_wdt: assert property (p_wdt) else $error("watchdog reset status wrong");
	a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear status wrong");
	a_sub: assert property (p_sub) else $error("borrow flags wrong");
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	a_pcl: assert property (p_pcl) else $error("pc low load wrong");
	a_rsp: assert property (p_rsp) else $error("response without read");
endmodule : bsr_banked_sfr_checker

bind bsr_banked_sfr bsr_banked_sfr_checker bsr_banked_sfr_checker_inst (
	.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .event_in(event_in),
	.small_package_in(small_package_in), .pc_inc_in(pc_inc_in), .pc_jump_in(pc_jump_in),
	.pc_target_in(pc_target_in), .rsp_out(rsp_out), .ext_out(ext_out), .pc_out(pc_out),
	.status_out(status_out), .option_out(option_out), .port_b_direction_out(port_b_direction_out),
	.interrupt_control_out(interrupt_control_out));

//--- verif/bsr_core_model.sv
// Partner: behavioural core issuing one register access per instruction
`timescale 1ns/100ps
module bsr_core_model
	import bsr_pkg::*;
(
	input  wire logic               clk_in,
	input  wire bsr_pkg::bsr_rsp_s  rsp_in,
	output bsr_pkg::bsr_req_s       req_out
);
	// Bus idles until the first instruction
	initial begin
		req_out = '0;
	end
	// Launch after an edge, taken at the next
	task automatic access(input logic rd_in, input logic wr_in, input logic [6:0] fa_in,
		input bsr_alu_op_e op_in, input logic [7:0] a_in, input logic [7:0] b_in,
		input bsr_flags_s fl_in, output logic [7:0] data_out);
		@(posedge clk_in);
		req_out <= {1'b1, rd_in, wr_in, fa_in, op_in, a_in, b_in, fl_in};
		@(posedge clk_in);
		// Released fields flip so a stale value cannot pass for a live one
		req_out <= {1'b0, ~req_out[29:0]};
		#1;
		data_out = rsp_in.valid ? rsp_in.rdata : 8'hxx;
	endtask : access
endmodule : bsr_core_model

//--- verif/testbench.sv
// Testbench: directed register access tests for the banked core register block
`timescale 1ns/100ps
module testbench;
	import bsr_pkg::*;
	logic        clk_in, rst_in, small_package_in, pc_inc_in, pc_jump_in;
	logic [10:0] pc_target_in;
	bsr_req_s    req;
	bsr_event_s  ev;
	bsr_rsp_s    rsp;
	bsr_ext_s    ext;
	logic [12:0] pc;
	logic [7:0]  st, opt, port_b_direction, interrupt_control, rd;
	int          num_errors = 0;
	int          checks_done = 0;
	bsr_alu_op_e sop [5] = '{ALU_SUB, ALU_SUB, ALU_SUB, ALU_SUB, ALU_ADD};
	logic [7:0]  sa [5]  = '{8'h05, 8'h03, 8'h10, 8'h07, 8'hf8};
	logic [7:0]  sb [5]  = '{8'h03, 8'h05, 8'h01, 8'h07, 8'h08};
	logic [2:0]  sfl [5] = '{3'b011, 3'b000, 3'b001, 3'b111, 3'b111};
	bsr_core_model bsr_core_model_inst (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
	bsr_banked_sfr bsr_banked_sfr_inst (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
		.event_in(ev), .small_package_in(small_package_in), .pc_inc_in(pc_inc_in),
		.pc_jump_in(pc_jump_in), .pc_target_in(pc_target_in), .rsp_out(rsp), .ext_out(ext),
		.pc_out(pc), .status_out(st), .option_out(opt), .port_b_direction_out(port_b_direction),
		.interrupt_control_out(interrupt_control));
	task chk13(input string what, input logic [12:0] exp, input logic [12:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk13
	task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		chk13(what, {5'h00, exp}, {5'h00, got});
	endtask : chk8
	task wr(input logic [6:0] fa, input logic [7:0] d);
		bsr_core_model_inst.access(1'b0, 1'b1, fa, ALU_PASS, 8'h00, d, 3'b000, rd);
	endtask : wr
	task rdr(input logic [6:0] fa);
		bsr_core_model_inst.access(1'b1, 1'b0, fa, ALU_PASS, 8'h00, 8'h00, 3'b000, rd);
	endtask : rdr
	// Plain move into status, the only safe way to alter it
	task wst(input logic [7:0] d, input logic [7:0] exp);
		wr(7'h03, d);
		chk8("status", exp, st);
	endtask : wst
	task pulse(input bsr_event_s e);
		@(posedge clk_in);
		ev <= e;
		@(posedge clk_in);
		ev <= '0;
		#1;
	endtask : pulse
	task end_sim;
		$display("Checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim
	// Free-running core clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// Cuts a hang short; the tests need well under a few hundred cycles
	initial begin
		repeat (5000) @(posedge clk_in);
		num_errors++;
		$display("BAD watchdog expected done seen hang");
		end_sim;
	end
	// Main sequence
	initial begin
		rst_in = 1'b1;
		small_package_in = 1'b1;
		pc_inc_in = 1'b0;
		pc_jump_in = 1'b0;
		pc_target_in = 11'h000;
		ev = '0;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk8("status", STATUS_POR, st);
		chk8("option", OPTION_RST, opt);
		chk8("interrupt_control", INTERRUPT_CONTROL_RST, interrupt_control);
		chk8("port_b_direction", PORT_B_DIRECTION_RST, port_b_direction);
		$display("test reset done");
		wst(8'h00, 8'h18);
		wst(8'h63, 8'h7b);
		rdr(7'h03);
		chk8("status read", 8'h7b, rd);
		wr(7'h04, 8'h5a);
		rdr(7'h05);
		chk8("unimplemented", 8'h00, rd);
		rdr(7'h20);
		chk13("foreign addr", 13'h01a0, {4'h0, ext.addr});
		chk8("foreign read", 8'h02, {6'h00, ext.valid, ext.wr});
		wr(7'h20, 8'ha5);
		chk8("foreign data", 8'ha5, ext.wdata);
		chk8("foreign write", 8'h03, {6'h00, ext.valid, ext.wr});
		wst(8'h43, 8'h5b);
		rdr(7'h04);
		chk8("pointer", 8'h5a, rd);
		wr(7'h0a, 8'hff);
		rdr(7'h0a);
		chk8("holding", 8'h1f, rd);
		wst(8'h63, 8'h7b);
		rdr(7'h0a);
		chk8("holding b3", 8'h1f, rd);
		wr(7'h02, 8'h34);
		chk13("pc", 13'h1f34, pc);
		wr(7'h0a, 8'h18);
		@(posedge clk_in);
		pc_target_in <= 11'h123;
		pc_jump_in <= 1'b1;
		@(posedge clk_in);
		pc_jump_in <= 1'b0;
		pc_inc_in <= 1'b1;
		@(posedge clk_in);
		pc_inc_in <= 1'b0;
		#1;
		chk13("pc", 13'h1924, pc);
		$display("test banking done");
		wst(8'h03, 8'h1b);
		bsr_core_model_inst.access(1'b0, 1'b1, 7'h03, ALU_PASS, 8'h00, 8'h00, 3'b100, rd);
		chk8("clear file", 8'h1f, st);
		rdr(7'h08);
		chk8("absent", 8'h00, rd);
		chk8("absent ext", 8'h00, {7'h00, ext.valid});
		for (int i = 0; i < 5; i++) begin
			bsr_core_model_inst.access(1'b0, 1'b0, 7'h20, sop[i], sa[i], sb[i], 3'b111, rd);
			chk8("alu flags", {5'b00011, sfl[i]}, st);
		end
		bsr_core_model_inst.access(1'b0, 1'b1, 7'h03, ALU_SUB, 8'h69, 8'h09, 3'b111, rd);
		chk8("status dest", 8'h7b, st);
		$display("test flags done");
		pulse(4'b0100);
		chk8("watchdog", 8'h0b, st);
		chk13("pc", PC_RST, pc);
		pulse(4'b0010);
		chk8("sleep", 8'h13, st);
		wst(8'he3, 8'hf3);
		wr(7'h0b, 8'h81);
		wr(7'h01, 8'h2a);
		wr(7'h06, 8'h3c);
		chk8("interrupt_control", 8'h81, interrupt_control);
		chk8("option", 8'h2a, opt);
		chk8("port_b_direction", 8'h3c, port_b_direction);
		pulse(4'b1000);
		chk8("master clear", 8'h13, st);
		chk8("interrupt_control kept", 8'h01, interrupt_control);
		chk8("option reset", OPTION_RST, opt);
		chk8("port_b_direction reset", PORT_B_DIRECTION_RST, port_b_direction);
		rdr(7'h0a);
		chk8("holding reset", 8'h00, rd);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk8("status", STATUS_POR, st);
		$display("test resets done");
		end_sim;
	end
endmodule : testbench
